/* hw/vout_supv.sv */
`timescale 1ns/1ns
// What this block does
// RULE1: Action field selects ignore, shutdown or invalid
// RULE2: Retry zero latches off after shutdown
// RULE3: Retry one to six bounds restart attempts
// RULE4: Retry seven restarts without limit
// RULE5: Delay field scales hiccup by rise time
// RULE6: Out-of-range writes flag invalid data, alert
// RULE7: Fault-free check window clears restart counter
// RULE8: Present fault at enable blocks start-up
// RULE9: Host sets fault limit above start-up input
// RULE10: High warning follows commanded voltage ratio
// RULE11: Command change never rewrites stored limits
// RULE12: High warning sets summary, warning bits, alert
// RULE13: High limit rounds up, 103 to 116
// RULE14: Low warning follows commanded voltage ratio
// RULE15: Low warning sets summary, warning bits, alert
// RULE16: Low limit rounds down, 84 to 97
// RULE17: Warning limits use word access, 16 bits
// RULE18: Fault sets byte, word, vout bits, alert
// RULE19: Hiccup counter loads rise time times scale
module vout_supv #(
  parameter int TW = 24
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire vout_supv_pkg::cmd_req_t cmd,
  output      vout_supv_pkg::cmd_rsp_t rsp,
  input  wire logic                  ov_fault_pin,
  input  wire logic                  enable,
  input  wire logic                  rel_mode,
  input  wire logic [15:0]           vout_cmd,
  input  wire logic [15:0]           vout_sense,
  input  wire logic [TW-1:0]         ton_rise,
  input  wire logic [TW-1:0]         ton_max,
  input  wire logic                  clear_faults,
  output      vout_supv_pkg::status_t status,
  output logic                       alert_n,
  output logic                       power_on,
  output logic                       latched_off,
  output logic [2:0]                 restart_count
);
  import vout_supv_pkg::*;

  typedef struct packed {
    state_t       st;
    logic [TW+2:0] timer;
    logic [2:0]   tries;
    logic [7:0]   resp;
    logic [15:0]  ovw_lim;
    logic [15:0]  uvw_lim;
    logic [7:0]   ov_ratio;
    logic [7:0]   uv_ratio;
    logic         sync0;
    logic         ov_flt;
    logic         ovf_prev;
    logic         ovw_prev;
    logic         uvw_prev;
    logic         pwr;
    logic         latched;
    logic         alert_n;
    status_t      stat;
    cmd_rsp_t     rsp;
  } regs_t;

  regs_t         s;
  regs_t         next_s;
  logic [15:0]   base;
  logic [7:0]    wr_up;
  logic [7:0]    wr_dn;
  logic [23:0]   sense100;
  logic          ovw_now;
  logic          uvw_now;
  logic          shut;
  logic          bad;
  logic [TW+2:0] hiccup_len;
  logic [TW+2:0] check_len;
  status_t       setv;

  // Smallest ratio whose threshold reaches the limit; zero when out of range
  function automatic logic [7:0] map_up(input logic [15:0] lim, input logic [15:0] b);
    logic [7:0]  r;
    logic [23:0] l100;
    r = 8'h00;
    l100 = 24'(lim) * 24'(PCT_FULL);
    for (int k = int'(OV_MAX); k >= int'(OV_MIN); k--) begin
      if (l100 <= 24'(b) * 24'(k)) r = 8'(k);
    end
    if (l100 < 24'(b) * 24'(OV_MIN)) r = 8'h00;
    return r;
  endfunction : map_up

  // Largest ratio whose threshold stays at or below the limit; zero when out of range
  function automatic logic [7:0] map_dn(input logic [15:0] lim, input logic [15:0] b);
    logic [7:0]  r;
    logic [23:0] l100;
    r = 8'h00;
    l100 = 24'(lim) * 24'(PCT_FULL);
    for (int k = int'(UV_MIN); k <= int'(UV_MAX); k++) begin
      if (l100 >= 24'(b) * 24'(k)) r = 8'(k);
    end
    if (l100 > 24'(b) * 24'(UV_MAX)) r = 8'h00;
    return r;
  endfunction : map_dn

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.rsp.valid = 1'b0;
    bad = 1'b0;
    setv = '0;
    // Fault pin synchroniser
    next_s.sync0 = ov_fault_pin;
    next_s.ov_flt = s.sync0;
    // Limits are mapped against unity in relative mode
    base = rel_mode ? REL_ONE : vout_cmd;
    wr_up = map_up(cmd.data, base);
    wr_dn = map_dn(cmd.data, base);

    // Command port
    if (cmd.valid && cmd.write) begin
      unique case (cmd.code)
        CMD_OV_RESP: begin
          if (cmd.word || cmd.data[ACT_HI:ACT_LO] == ACT_INVALID) begin
            bad = 1'b1; // RULE1 RULE6
          end else begin
            next_s.resp = cmd.data[7:0];
          end
        end
        CMD_OV_WARN: begin
          if (!cmd.word || wr_up == 8'h00) begin
            bad = 1'b1; // RULE6 RULE17
          end else begin
            next_s.ovw_lim = cmd.data;
            next_s.ov_ratio = wr_up; // RULE13
          end
        end
        CMD_UV_WARN: begin
          if (!cmd.word || wr_dn == 8'h00) begin
            bad = 1'b1; // RULE6 RULE17
          end else begin
            next_s.uvw_lim = cmd.data;
            next_s.uv_ratio = wr_dn; // RULE16
          end
        end
        default: bad = 1'b0;
      endcase
    end else if (cmd.valid) begin
      next_s.rsp.valid = 1'b1;
      unique case (cmd.code)
        CMD_OV_RESP: next_s.rsp.data = {8'h00, s.resp};
        CMD_OV_WARN: next_s.rsp.data = s.ovw_lim; // RULE11
        CMD_UV_WARN: next_s.rsp.data = s.uvw_lim;
        default:     next_s.rsp.data = 16'h0000;
      endcase
    end

    // Warning comparisons against the live command
    sense100 = 24'(vout_sense) * 24'(PCT_FULL);
    ovw_now = sense100 > 24'(vout_cmd) * 24'(s.ov_ratio); // RULE10
    uvw_now = sense100 < 24'(vout_cmd) * 24'(s.uv_ratio); // RULE14
    next_s.ovw_prev = ovw_now;
    next_s.uvw_prev = uvw_now;
    next_s.ovf_prev = s.ov_flt;

    // Status sets on new events
    setv.cml_data = bad; // RULE6
    if (s.ov_flt && !s.ovf_prev) begin
      setv.ov_fault = 1'b1; // RULE18
      setv.vout_ovf = 1'b1;
      setv.vout_sum = 1'b1;
    end
    if (ovw_now && !s.ovw_prev) begin
      setv.vout_ovw = 1'b1; // RULE12
      setv.vout_sum = 1'b1;
    end
    if (uvw_now && !s.uvw_prev) begin
      setv.vout_uvw = 1'b1; // RULE15
      setv.vout_sum = 1'b1;
    end
    // Set beats a same-cycle clear
    next_s.stat = status_t'((s.stat & ~{$bits(status_t){clear_faults}}) | setv);
    next_s.alert_n = ~(|next_s.stat);

    // Restart sequencing
    shut = s.ov_flt && (s.resp[ACT_HI:ACT_LO] == ACT_SHUT_A ||
                        s.resp[ACT_HI:ACT_LO] == ACT_SHUT_B); // RULE1
    hiccup_len = (TW+3)'(ton_rise) *
                 (TW+3)'((s.resp[SCALE_HI:SCALE_LO] == 3'h0) ? 3'h1
                         : s.resp[SCALE_HI:SCALE_LO]); // RULE5 RULE19
    check_len = (ton_max != '0) ? (TW+3)'(ton_max) : (TW+3)'(ton_rise); // RULE7
    if (s.timer != '0) next_s.timer = s.timer - (TW+3)'(1);
    unique case (s.st)
      ST_OFF: begin
        if (enable && !s.ov_flt) begin // RULE8
          next_s.st = ST_RISE;
          next_s.timer = (TW+3)'(ton_rise);
        end
      end
      ST_RISE: begin
        if (s.timer <= (TW+3)'(1)) begin
          next_s.st = ST_CHECK;
          next_s.timer = check_len;
        end
      end
      ST_CHECK: begin
        if (s.timer <= (TW+3)'(1)) begin
          next_s.st = ST_ON;
          next_s.tries = 3'h0; // RULE7
        end
      end
      ST_ON: next_s.st = ST_ON;
      ST_HICCUP: begin
        if (s.timer <= (TW+3)'(1)) begin // RULE19
          next_s.st = ST_RISE;
          next_s.timer = (TW+3)'(ton_rise);
          if (s.tries != 3'h7) next_s.tries = s.tries + 3'h1;
        end
      end
      ST_LATCHED: next_s.st = ST_LATCHED;
    endcase
    // Shutdown decision and turn-off override
    if (!enable) begin
      next_s.st = ST_OFF;
      next_s.tries = 3'h0;
    end else if (shut && (s.st == ST_RISE || s.st == ST_CHECK || s.st == ST_ON)) begin
      if (s.resp[RETRY_HI:RETRY_LO] == RETRY_LATCH) begin
        next_s.st = ST_LATCHED; // RULE2
      end else if (s.resp[RETRY_HI:RETRY_LO] == RETRY_FOREVER ||
                   s.tries < s.resp[RETRY_HI:RETRY_LO]) begin
        next_s.st = ST_HICCUP; // RULE3 RULE4
        next_s.timer = hiccup_len;
      end else begin
        next_s.st = ST_LATCHED; // RULE3
      end
    end
    next_s.pwr = next_s.st == ST_RISE || next_s.st == ST_CHECK || next_s.st == ST_ON;
    next_s.latched = next_s.st == ST_LATCHED;
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s          <= '0;
      s.st       <= ST_OFF;
      s.resp     <= RST_OV_RESP;
      s.ovw_lim  <= RST_OV_WARN;
      s.uvw_lim  <= RST_UV_WARN;
      s.ov_ratio <= RST_OV_RATIO;
      s.uv_ratio <= RST_UV_RATIO;
      s.alert_n  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign rsp           = s.rsp;
  assign status        = s.stat;
  assign alert_n       = s.alert_n;
  assign power_on      = s.pwr;
  assign latched_off   = s.latched;
  assign restart_count = s.tries;

  // Checks
  property p_ignore;
    @(posedge core_clk) disable iff (!nrst)
    s.st == ST_ON && s.resp[ACT_HI:ACT_LO] == ACT_IGNORE && enable |=> s.st == ST_ON;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore action left run"); // RULE1

  property p_latch;
    @(posedge core_clk) disable iff (!nrst)
    enable && shut && (s.st == ST_RISE || s.st == ST_CHECK || s.st == ST_ON) &&
    s.resp[RETRY_HI:RETRY_LO] == RETRY_LATCH
    |=> s.st == ST_LATCHED && s.latched;
  endproperty
  a_latch: assert property (p_latch) else $error("retry zero did not latch"); // RULE2

  property p_limit;
    @(posedge core_clk) disable iff (!nrst)
    $rose(s.st == ST_HICCUP) |-> s.resp[RETRY_HI:RETRY_LO] == RETRY_FOREVER ||
      $past(s.tries) < s.resp[RETRY_HI:RETRY_LO];
  endproperty
  a_limit: assert property (p_limit) else $error("hiccup beyond retry limit"); // RULE3

  property p_forever;
    @(posedge core_clk) disable iff (!nrst)
    enable && shut && (s.st == ST_RISE || s.st == ST_CHECK || s.st == ST_ON) &&
    s.resp[RETRY_HI:RETRY_LO] == RETRY_FOREVER
    |=> s.st == ST_HICCUP;
  endproperty
  a_forever: assert property (p_forever) else $error("endless retry stopped"); // RULE4

  property p_hiccup_len;
    @(posedge core_clk) disable iff (!nrst)
    $rose(s.st == ST_HICCUP) |-> s.timer == $past(hiccup_len);
  endproperty
  a_hiccup_len: assert property (p_hiccup_len) else $error("hiccup length wrong"); // RULE5 RULE19

  property p_invalid;
    @(posedge core_clk) disable iff (!nrst)
    cmd.valid && cmd.write && !cmd.word && cmd.code == CMD_OV_RESP &&
    cmd.data[ACT_HI:ACT_LO] == ACT_INVALID
    |=> s.resp == $past(s.resp) && s.stat.cml_data && !alert_n;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid write accepted"); // RULE6

  property p_success;
    @(posedge core_clk) disable iff (!nrst)
    enable && !shut && s.st == ST_CHECK && s.timer <= (TW+3)'(1)
    |=> s.st == ST_ON && restart_count == 3'h0;
  endproperty
  a_success: assert property (p_success) else $error("success not recorded"); // RULE7

  property p_no_start;
    @(posedge core_clk) disable iff (!nrst)
    s.st == ST_OFF && s.ov_flt |=> s.st == ST_OFF && !power_on;
  endproperty
  a_no_start: assert property (p_no_start) else $error("started into fault"); // RULE8

  property p_ovw;
    @(posedge core_clk) disable iff (!nrst)
    ovw_now && !s.ovw_prev |=> status.vout_ovw && status.vout_sum && !alert_n;
  endproperty
  a_ovw: assert property (p_ovw) else $error("high warning not flagged"); // RULE10 RULE12

  property p_uvw;
    @(posedge core_clk) disable iff (!nrst)
    uvw_now && !s.uvw_prev |=> status.vout_uvw && status.vout_sum && !alert_n;
  endproperty
  a_uvw: assert property (p_uvw) else $error("low warning not flagged"); // RULE14 RULE15

  property p_ratios;
    @(posedge core_clk) disable iff (!nrst)
    s.ov_ratio >= OV_MIN && s.ov_ratio <= OV_MAX && s.uv_ratio >= UV_MIN &&
    s.uv_ratio <= UV_MAX;
  endproperty
  a_ratios: assert property (p_ratios) else $error("ratio out of range"); // RULE13 RULE16

  property p_ovf;
    @(posedge core_clk) disable iff (!nrst)
    s.ov_flt && !s.ovf_prev |=> status.ov_fault && status.vout_ovf && status.vout_sum;
  endproperty
  a_ovf: assert property (p_ovf) else $error("fault bits not set"); // RULE18

  c_hiccup:  cover property (@(posedge core_clk) disable iff (!nrst)
    s.st == ST_HICCUP ##1 s.st == ST_RISE);
  c_latched: cover property (@(posedge core_clk) disable iff (!nrst)
    $rose(s.latched));
  c_on:      cover property (@(posedge core_clk) disable iff (!nrst)
    s.st == ST_CHECK ##1 s.st == ST_ON);
endmodule : vout_supv

/* include/vout_supv_pkg.sv */
package vout_supv_pkg;
  // Command codes
  localparam logic [7:0]  CMD_OV_RESP   = 8'h41;
  localparam logic [7:0]  CMD_OV_WARN   = 8'h42;
  localparam logic [7:0]  CMD_UV_WARN   = 8'h43;
  // Fault response field positions
  localparam int          ACT_HI        = 7;
  localparam int          ACT_LO        = 6;
  localparam int          RETRY_HI      = 5;
  localparam int          RETRY_LO      = 3;
  localparam int          SCALE_HI      = 2;
  localparam int          SCALE_LO      = 0;
  // Field encodings
  localparam logic [1:0]  ACT_IGNORE    = 2'h0;
  localparam logic [1:0]  ACT_SHUT_A    = 2'h1;
  localparam logic [1:0]  ACT_SHUT_B    = 2'h2;
  localparam logic [1:0]  ACT_INVALID   = 2'h3;
  localparam logic [2:0]  RETRY_LATCH   = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER = 3'h7;
  // Reset values
  localparam logic [7:0]  RST_OV_RESP   = 8'h80;
  localparam logic [15:0] RST_OV_WARN   = 16'h1199;
  localparam logic [15:0] RST_UV_WARN   = 16'h0E67;
  localparam logic [7:0]  RST_OV_RATIO  = 8'h6E;
  localparam logic [7:0]  RST_UV_RATIO  = 8'h5A;
  // Hardware ratio ranges, percent of commanded voltage
  localparam logic [7:0]  OV_MIN        = 8'h67;
  localparam logic [7:0]  OV_MAX        = 8'h74;
  localparam logic [7:0]  UV_MIN        = 8'h54;
  localparam logic [7:0]  UV_MAX        = 8'h61;
  localparam logic [7:0]  PCT_FULL      = 8'h64;
  // Unity value of the relative format
  localparam logic [15:0] REL_ONE       = 16'h1000;

  typedef enum logic [2:0] {ST_OFF, ST_RISE, ST_CHECK, ST_ON, ST_HICCUP, ST_LATCHED} state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } cmd_rsp_t;

  typedef struct packed {
    logic ov_fault;
    logic vout_sum;
    logic vout_ovf;
    logic vout_ovw;
    logic vout_uvw;
    logic cml_data;
  } status_t;
endpackage : vout_supv_pkg

/* test/pmbus_host_model.sv */
`timescale 1ns/1ns
module pmbus_host_model (
  input  wire logic                    core_clk,
  output      vout_supv_pkg::cmd_req_t cmd,
  input  wire vout_supv_pkg::cmd_rsp_t rsp
);
  import vout_supv_pkg::*;

  initial cmd = '0;

  // One strobe per call, launched just after an edge, dropped after the taking edge
  task automatic issue(input logic w, input logic wd, input logic [7:0] c,
                       input logic [15:0] d);
    @(posedge core_clk);
    #1;
    cmd = '{valid: 1'b1, write: w, word: wd, code: c, data: d};
    @(posedge core_clk);
    #1;
    cmd.valid = 1'b0;
    cmd.data = ~d; // Idle data never repeats the last value
  endtask : issue

  // Write of a byte or a word as the caller says
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic wd);
    issue(1'b1, wd, c, d);
  endtask : wr

  // Limits read as words, the response setting as a byte
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    issue(1'b0, c != CMD_OV_RESP, c, 16'h0000);
    d = rsp.valid ? rsp.data : 16'hXXXX;
  endtask : rd
endmodule : pmbus_host_model

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import vout_supv_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  cmd_req_t    cmd;
  cmd_rsp_t    rsp;
  status_t     status;
  logic        ov_fault_pin = 1'b0;
  logic        enable = 1'b0;
  logic        rel_mode = 1'b1;
  logic        clear_faults = 1'b0;
  logic [15:0] vout_cmd = 16'd1000;
  logic [15:0] vout_sense = 16'd1000;
  logic [7:0]  ton_rise = 8'h04;
  logic [7:0]  ton_max = 8'h00;
  logic        alert_n;
  logic        power_on;
  logic        latched_off;
  logic [2:0]  restart_count;
  logic [15:0] rdat;
  int          num_errors = 0;
  int          comparisons = 0;
  int          lo1;
  int          lo4;

  always #5 core_clk = ~core_clk;

  pmbus_host_model u_host (.core_clk(core_clk), .cmd(cmd), .rsp(rsp));

  vout_supv #(.TW(8)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .cmd(cmd), .rsp(rsp),
    .ov_fault_pin(ov_fault_pin), .enable(enable), .rel_mode(rel_mode),
    .vout_cmd(vout_cmd), .vout_sense(vout_sense), .ton_rise(ton_rise),
    .ton_max(ton_max), .clear_faults(clear_faults), .status(status),
    .alert_n(alert_n), .power_on(power_on), .latched_off(latched_off),
    .restart_count(restart_count)
  );

  // Step to just after an edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic clr;
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(1);
  endtask : clr

  task automatic test_done;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // Refused write: flag raised, alert low, then cleared
  task automatic inv(input logic [7:0] c, input logic [15:0] d, input logic wd);
    u_host.wr(c, d, wd);
    chk({14'h0, status.cml_data, alert_n}, 16'h0002);
    clr;
  endtask : inv

  task automatic t_regs;
    u_host.rd(CMD_OV_RESP, rdat);
    chk(rdat, {8'h00, RST_OV_RESP});
    u_host.rd(CMD_OV_WARN, rdat);
    chk(rdat, RST_OV_WARN);
    u_host.rd(CMD_UV_WARN, rdat);
    chk(rdat, RST_UV_WARN);
    u_host.rd(8'h50, rdat);
    chk(rdat, 16'h0000);
    chk({15'h0, alert_n}, 16'h0001);
    $display("test regs done");
  endtask : t_regs

  task automatic t_invalid;
    inv(CMD_OV_RESP, 16'h00C0, 1'b0);
    inv(CMD_OV_RESP, 16'h0080, 1'b1);
    inv(CMD_OV_WARN, 16'h1090, 1'b0);
    inv(CMD_OV_WARN, 16'h12B8, 1'b1);
    inv(CMD_OV_WARN, 16'h1000, 1'b1);
    inv(CMD_UV_WARN, 16'h0FAE, 1'b1);
    inv(CMD_UV_WARN, 16'h0D00, 1'b1);
    u_host.rd(CMD_OV_RESP, rdat);
    chk(rdat, 16'h0080);
    u_host.rd(CMD_OV_WARN, rdat);
    chk(rdat, RST_OV_WARN);
    u_host.rd(CMD_UV_WARN, rdat);
    chk(rdat, RST_UV_WARN);
    $display("test invalid done");
  endtask : t_invalid

  // Ratios 104 and 93 after rounding, tried against moving commands
  task automatic t_warn;
    logic [15:0] cv [8] = '{1000, 1000, 2000, 2000, 2000, 2000, 1000, 1000};
    logic [15:0] sv [8] = '{1040, 1041, 2080, 2081, 1860, 1859, 930, 929};
    logic [2:0]  ev [8] = '{3'b000, 3'b110, 3'b000, 3'b110, 3'b000, 3'b101, 3'b000, 3'b101};
    u_host.wr(CMD_OV_WARN, 16'h1090, 1'b1);
    u_host.wr(CMD_UV_WARN, 16'h0F00, 1'b1);
    chk({15'h0, status.cml_data}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      vout_cmd = cv[i];
      vout_sense = sv[i];
      cyc(3);
      chk({12'h0, status.vout_sum, status.vout_ovw, status.vout_uvw, alert_n}, {12'h0, ev[i], ~|ev[i]});
      clr;
    end
    rel_mode = 1'b0;
    u_host.wr(CMD_OV_WARN, 16'h041A, 1'b1);
    vout_cmd = 16'd1010;
    cyc(2);
    u_host.rd(CMD_OV_WARN, rdat);
    chk(rdat, 16'h041A);
    $display("test warn done");
  endtask : t_warn

  // Turn on with the fault pin low, as the host keeps it at start-up
  task automatic start(input logic [7:0] cfg);
    enable = 1'b0;
    ov_fault_pin = 1'b0;
    cyc(3);
    clr;
    u_host.wr(CMD_OV_RESP, {8'h00, cfg}, 1'b0);
    enable = 1'b1;
    repeat (50) if (!power_on) cyc(1);
  endtask : start

  task automatic low_len(output int n);
    n = 0;
    repeat (100) if (!power_on) cyc(1);
    repeat (100) if (power_on) cyc(1);
    repeat (100) if (!power_on) begin
      n++;
      cyc(1);
    end
  endtask : low_len

  task automatic t_restart;
    start(8'h80);
    ov_fault_pin = 1'b1;
    cyc(6);
    chk({13'h0, status.ov_fault, status.vout_sum, status.vout_ovf}, 16'h0007);
    ov_fault_pin = 1'b0;
    cyc(30);
    chk({14'h0, latched_off, power_on}, 16'h0002);
    start(8'h51);
    ov_fault_pin = 1'b1;
    repeat (300) if (!latched_off) cyc(1);
    chk({12'h0, latched_off, restart_count}, 16'h000A);
    start(8'hB9);
    ov_fault_pin = 1'b1;
    low_len(lo1);
    u_host.wr(CMD_OV_RESP, 16'h00BC, 1'b0);
    low_len(lo4);
    low_len(lo4);
    chk(16'(lo4 - lo1), {8'h00, ton_rise} * 16'd3);
    cyc(200);
    chk({15'h0, latched_off}, 16'h0000);
    ov_fault_pin = 1'b0;
    cyc(60);
    chk({12'h0, power_on, restart_count}, 16'h0008);
    $display("test restart done");
  endtask : t_restart

  task automatic t_ignore;
    start(8'h00);
    ov_fault_pin = 1'b1;
    cyc(20);
    chk({13'h0, power_on, latched_off, status.ov_fault}, 16'h0005);
    enable = 1'b0;
    cyc(3);
    enable = 1'b1;
    cyc(30);
    chk({15'h0, power_on}, 16'h0000);
    enable = 1'b0;
    ov_fault_pin = 1'b0;
    $display("test ignore done");
  endtask : t_ignore

  // Nonzero turn-on limit stretches the success window
  task automatic t_window;
    ton_max = 8'h14;
    start(8'hB9);
    ov_fault_pin = 1'b1;
    repeat (50) if (power_on) cyc(1);
    ov_fault_pin = 1'b0;
    repeat (50) if (!power_on) cyc(1);
    cyc(12);
    chk({12'h0, power_on, restart_count}, 16'h0009);
    cyc(20);
    chk({12'h0, power_on, restart_count}, 16'h0008);
    ton_max = 8'h00;
    enable = 1'b0;
    $display("test window done");
  endtask : t_window

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    num_errors++;
    test_done;
  end

  initial begin
    cyc(20);
    nrst = 1'b1;
    t_regs;
    t_invalid;
    t_warn;
    t_restart;
    t_ignore;
    t_window;
    test_done;
  end
endmodule : testbench
